// file: design/pfs_pkg.sv
// Package: constants for the fault supervisor
package pfs_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_HZ = 40000000;

  // ==========================================================
  // Times as printed
  localparam int unsigned BO_FILT_MS    = 50;
  localparam int unsigned LL_FILT_MS    = 25;
  localparam int unsigned SECONDARY_OVERVOLTAGE_BLANK_US = 1;
  localparam int unsigned SECONDARY_OVERVOLTAGE_CLR_US   = 800;
  localparam int unsigned OVS_OFF_US    = 800;
  localparam int unsigned GND_FLT_US    = 200;

  // ==========================================================
  // Cycle counts
  localparam int unsigned BO_FILT_CYC   = BO_FILT_MS * (CLK_HZ / 1000);
  localparam int unsigned LL_FILT_CYC   = LL_FILT_MS * (CLK_HZ / 1000);
  localparam int unsigned SECONDARY_OVERVOLTAGE_BLANK_CYC =
    SECONDARY_OVERVOLTAGE_BLANK_US * (CLK_HZ / 1000000);
  localparam int unsigned SECONDARY_OVERVOLTAGE_CLR_CYC  = SECONDARY_OVERVOLTAGE_CLR_US * (CLK_HZ / 1000000);
  localparam int unsigned OVS_OFF_CYC   = OVS_OFF_US * (CLK_HZ / 1000000);
  localparam int unsigned GND_FLT_CYC   = GND_FLT_US * (CLK_HZ / 1000000);

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FAULT_OFS  = 8'h08;

  // Control fields
  localparam int unsigned CTRL_FOLLOW_BIT = 0;
  localparam int unsigned CTRL_VER_BIT    = 1;
  localparam logic [1:0]  CTRL_RST        = 2'h0;

  // Counter width
  localparam int unsigned CNT_W = 22;

  typedef enum logic [1:0] {
    PFS_OFF,
    PFS_WAIT,
    PFS_RUN
  } pfs_state_t;

endpackage : pfs_pkg

// file: design/pfs_supervisor.sv
// Module: supervisory fault logic for a boost power factor stage
`timescale 1ns/1ps

// ==========================================================
module pfs_supervisor #(
  parameter int unsigned BO_FILT_CYC    = pfs_pkg::BO_FILT_CYC,
  parameter int unsigned LL_FILT_CYC    = pfs_pkg::LL_FILT_CYC,
  parameter int unsigned SECONDARY_OVERVOLTAGE_CLR_CYC   = pfs_pkg::SECONDARY_OVERVOLTAGE_CLR_CYC,
  parameter int unsigned OVS_OFF_CYC    = pfs_pkg::OVS_OFF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Comparator inputs
  input  wire logic        sns_above_boh,
  input  wire logic        sns_below_bol,
  input  wire logic        sns_above_hl,
  input  wire logic        sns_below_ll,
  input  wire logic        undervoltage_lockout,
  input  wire logic        thermal_hot,
  input  wire logic        thermal_cool,
  input  wire logic        undervoltage_protection,
  input  wire logic        static_overvoltage,
  input  wire logic        demag_phase,
  input  wire logic        sense_above_secondary_overvoltage,
  input  wire logic        gnd_open,
  input  wire logic        fb_floating,
  input  wire logic        sense_pin_fault,
  input  wire logic        overstress_detect,
  // Outputs
  output logic             drive_enable,
  output logic             pwm_latch_reset,
  output logic             ctrl_sink_enable,
  output logic             ctrl_ground,
  output logic             power_good_signal,
  output logic             on_time_ground,
  output logic             ramp_steep,
  output logic             vref_low_select,
  output logic             blocks_powered,
  output logic             brownout_not_ok_flag,
  output logic             low_line_flag,
  output logic             secondary_overvoltage
);

  localparam int unsigned NSYNC = 15;
  localparam int unsigned CW = pfs_pkg::CNT_W;
  localparam int unsigned BLANK_CYC = pfs_pkg::SECONDARY_OVERVOLTAGE_BLANK_CYC;
  localparam int unsigned GND_CYC = pfs_pkg::GND_FLT_CYC;

  // ==========================================================
  // Input synchronisers
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] in_q;

  assign raw_in = {sns_above_boh, sns_below_bol, sns_above_hl,
                   sns_below_ll, undervoltage_lockout, thermal_hot,
                   thermal_cool, undervoltage_protection,
                   static_overvoltage, demag_phase, sense_above_secondary_overvoltage,
                   gnd_open, fb_floating, sense_pin_fault,
                   overstress_detect};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else if (clk_en) begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic boh_s, bol_s, hl_s, ll_s, undervoltage_lockout_s, hot_s, cool_s, uvp_s;
  logic sovp_s, demag_s, secondary_overvoltage_s, gnd_s, fbf_s, spf_s, ovs_s;
  assign {boh_s, bol_s, hl_s, ll_s, undervoltage_lockout_s, hot_s, cool_s, uvp_s,
          sovp_s, demag_s, secondary_overvoltage_s, gnd_s, fbf_s, spf_s, ovs_s} = in_q;

  // Saturating counter step
  function automatic logic [CW-1:0] cnt_step(input logic run,
                                             input logic [CW-1:0] c);
    if (!run) begin
      cnt_step = '0;
    end else if (c == {CW{1'b1}}) begin
      cnt_step = c;
    end else begin
      cnt_step = c + 1'b1;
    end
  endfunction : cnt_step

  // ==========================================================
  // Registers
  logic [1:0] ctrl_q;
  logic       follow_en;
  assign follow_en = ctrl_q[pfs_pkg::CTRL_FOLLOW_BIT] &
                     ctrl_q[pfs_pkg::CTRL_VER_BIT];

  // ==========================================================
  // Brown-out
  logic          brownout_not_ok_flag_q;
  logic          bo_fault_q;
  logic [CW-1:0] bo_cnt_q;
  pfs_pkg::pfs_state_t st_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bo_cnt_q <= '0;
    end else if (clk_en) begin
      bo_cnt_q <= cnt_step(bol_s && !brownout_not_ok_flag_q, bo_cnt_q);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      brownout_not_ok_flag_q <= 1'b1;
    end else if (clk_en) begin
      if (brownout_not_ok_flag_q && boh_s) begin
        brownout_not_ok_flag_q <= 1'b0;
      end else if (!brownout_not_ok_flag_q && st_q == pfs_pkg::PFS_RUN &&
                   bo_cnt_q >= CW'(BO_FILT_CYC - 1)) begin
        brownout_not_ok_flag_q <= 1'b1;
      end
    end
  end

  // Brown-out fault held until brown-in, stops on static OVP
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bo_fault_q <= 1'b0;
    end else if (clk_en) begin
      if (!brownout_not_ok_flag_q) begin
        bo_fault_q <= 1'b0;
      end else if (st_q == pfs_pkg::PFS_RUN && sovp_s) begin
        bo_fault_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Line range
  logic          low_line_flag_q;
  logic [CW-1:0] ll_cnt_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ll_cnt_q <= '0;
    end else if (clk_en) begin
      ll_cnt_q <= cnt_step(ll_s && !low_line_flag_q, ll_cnt_q);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_line_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (hl_s) begin
        low_line_flag_q <= 1'b0;
      end else if (ll_cnt_q >= CW'(LL_FILT_CYC - 1)) begin
        low_line_flag_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Thermal
  logic tsd_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tsd_q <= 1'b0;
    end else if (clk_en) begin
      if (hot_s) begin
        tsd_q <= 1'b1;
      end else if (cool_s) begin
        tsd_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Secondary overvoltage
  logic          secondary_overvoltage_q;
  logic [CW-1:0] blank_cnt_q;
  logic [CW-1:0] secondary_overvoltage_tmr_q;
  logic          secondary_overvoltage_tick;

  assign secondary_overvoltage_tick = (secondary_overvoltage_tmr_q >= CW'(SECONDARY_OVERVOLTAGE_CLR_CYC - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blank_cnt_q <= '0;
      secondary_overvoltage_tmr_q  <= '0;
    end else if (clk_en) begin
      blank_cnt_q <= cnt_step(demag_s && secondary_overvoltage_s, blank_cnt_q);
      secondary_overvoltage_tmr_q  <= secondary_overvoltage_tick ? '0 : secondary_overvoltage_tmr_q + 1'b1;
    end
  end

  // Set wins over periodic clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secondary_overvoltage_q <= 1'b0;
    end else if (clk_en) begin
      if (blank_cnt_q >= CW'(BLANK_CYC - 1)) begin
        secondary_overvoltage_q <= 1'b1;
      end else if (secondary_overvoltage_tick) begin
        secondary_overvoltage_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pin faults and overstress
  logic [CW-1:0] gnd_cnt_q;
  logic          gnd_fault_q;
  logic [CW-1:0] ovs_cnt_q;
  logic          ovs_busy;

  assign ovs_busy = (ovs_cnt_q != '0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gnd_cnt_q   <= '0;
      gnd_fault_q <= 1'b0;
    end else if (clk_en) begin
      gnd_cnt_q   <= cnt_step(gnd_s, gnd_cnt_q);
      gnd_fault_q <= gnd_s && (gnd_cnt_q >= CW'(GND_CYC - 1));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovs_cnt_q <= '0;
    end else if (clk_en) begin
      if (ovs_s && !ovs_busy) begin
        ovs_cnt_q <= CW'(OVS_OFF_CYC);
      end else if (ovs_busy) begin
        ovs_cnt_q <= ovs_cnt_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // Operating state
  logic off_cond;
  assign off_cond = undervoltage_lockout_s || tsd_q || uvp_s || bo_fault_q ||
                    gnd_fault_q || fbf_s || spf_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= pfs_pkg::PFS_OFF;
    end else if (clk_en) begin
      unique case (st_q)
        pfs_pkg::PFS_OFF: begin
          if (!off_cond) begin
            st_q <= pfs_pkg::PFS_WAIT;
          end
        end
        pfs_pkg::PFS_WAIT: begin
          if (off_cond) begin
            st_q <= pfs_pkg::PFS_OFF;
          end else if (!brownout_not_ok_flag_q) begin
            st_q <= pfs_pkg::PFS_RUN;
          end
        end
        pfs_pkg::PFS_RUN: begin
          if (off_cond) begin
            st_q <= pfs_pkg::PFS_OFF;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  logic running;
  assign running = (st_q == pfs_pkg::PFS_RUN);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_enable      <= 1'b0;
      pwm_latch_reset   <= 1'b0;
      ctrl_sink_enable  <= 1'b0;
      ctrl_ground       <= 1'b1;
      power_good_signal <= 1'b0;
      on_time_ground    <= 1'b1;
      ramp_steep        <= 1'b1;
      vref_low_select   <= 1'b0;
      blocks_powered    <= 1'b0;
    end else if (clk_en) begin
      drive_enable      <= running && !ovs_busy;
      pwm_latch_reset   <= secondary_overvoltage_q;
      ctrl_sink_enable  <= running && brownout_not_ok_flag_q;
      ctrl_ground       <= !running;
      power_good_signal <= running;
      on_time_ground    <= !running;
      ramp_steep        <= !low_line_flag_q;
      vref_low_select   <= follow_en && running && low_line_flag_q;
      blocks_powered    <= (st_q != pfs_pkg::PFS_OFF);
    end
  end

  assign brownout_not_ok_flag  = brownout_not_ok_flag_q;
  assign low_line_flag         = low_line_flag_q;
  assign secondary_overvoltage = secondary_overvoltage_q;

  // ==========================================================
  // Wishbone slave
  logic hit;
  assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= pfs_pkg::CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= hit;
      if (hit && wb_we_i && wb_adr_i == pfs_pkg::CTRL_OFS &&
          wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[1:0];
      end
      if (hit && !wb_we_i) begin
        unique case (wb_adr_i)
          pfs_pkg::CTRL_OFS:   wb_dat_o <= {30'h0, ctrl_q};
          pfs_pkg::STATUS_OFS: wb_dat_o <= {24'h0, blocks_powered,
                                            drive_enable, running,
                                            tsd_q, secondary_overvoltage_q, follow_en,
                                            low_line_flag_q, brownout_not_ok_flag_q};
          pfs_pkg::FAULT_OFS:  wb_dat_o <= {25'h0, ovs_busy, spf_s,
                                            fbf_s, gnd_fault_q,
                                            bo_fault_q, uvp_s, undervoltage_lockout_s};
          default:             wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule : pfs_supervisor

// file: sim/pfs_stage_model.sv
// Sense network model: line level and die temperature to comparators
`timescale 1ns/1ps
module pfs_stage_model #(
  parameter int BOH_MV = 1000,
  parameter int BOL_MV = 900
) (
  input  int   line_mv,
  input  int   temp_c,
  output logic sns_above_boh,
  output logic sns_below_bol,
  output logic sns_above_hl,
  output logic sns_below_ll,
  output logic thermal_hot,
  output logic thermal_cool
);
  // ==========
  // Comparators
  assign sns_above_boh = (line_mv > BOH_MV);
  assign sns_below_bol = (line_mv < BOL_MV);
  assign sns_above_hl  = (line_mv > 1801);
  assign sns_below_ll  = (line_mv < 1392);
  assign thermal_hot   = (temp_c > 150);
  assign thermal_cool  = (temp_c < 100);
endmodule : pfs_stage_model

// file: sim/pfs_supervisor_sva.sv
// Checker: port properties of the fault supervisor
`timescale 1ns/1ps
module pfs_supervisor_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic drive_enable,
  input wire logic ctrl_ground,
  input wire logic on_time_ground,
  input wire logic power_good_signal,
  input wire logic thermal_hot,
  input wire logic undervoltage_lockout,
  input wire logic fb_floating,
  input wire logic secondary_overvoltage,
  input wire logic pwm_latch_reset,
  input wire logic vref_low_select,
  input wire logic low_line_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // Bus
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not given");
  property p_ackp;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackp: assert property (p_ackp)
    else $error("ack longer than one cycle");
  // ==========
  // Off state and faults
  property p_off;
    ctrl_ground |-> !drive_enable && on_time_ground && !power_good_signal;
  endproperty
  a_off: assert property (p_off)
    else $error("off outputs wrong");
  property p_hot;
    thermal_hot [*8] |-> !drive_enable;
  endproperty
  a_hot: assert property (p_hot)
    else $error("drive while hot");
  property p_undervoltage_lockout;
    undervoltage_lockout [*8] |-> !drive_enable;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout)
    else $error("drive in lockout");
  property p_fbf;
    fb_floating [*8] |-> !drive_enable;
  endproperty
  a_fbf: assert property (p_fbf)
    else $error("drive with floating feedback");
  property p_secondary_overvoltage;
    $rose(secondary_overvoltage) |-> ##[0:1] pwm_latch_reset;
  endproperty
  a_secondary_overvoltage: assert property (p_secondary_overvoltage)
    else $error("pwm latch not reset");
  property p_vref;
    vref_low_select |-> low_line_flag || $past(low_line_flag);
  endproperty
  a_vref: assert property (p_vref)
    else $error("low reference at high line");
  c_ll: cover property ($rose(low_line_flag));
  c_ov2: cover property ($rose(secondary_overvoltage));
  c_off: cover property ($rose(ctrl_ground));
endmodule : pfs_supervisor_sva
bind pfs_supervisor pfs_supervisor_sva chk_i (
  .core_clk, .rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .drive_enable,
  .ctrl_ground, .on_time_ground, .power_good_signal, .thermal_hot,
  .undervoltage_lockout, .fb_floating, .secondary_overvoltage,
  .pwm_latch_reset, .vref_low_select, .low_line_flag
);

// file: sim/pfs_supervisor_test.sv
// Testbench for the fault supervisor
`timescale 1ns/1ps
module pfs_supervisor_test;
  // ==========
  // Signals
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic demag_phase = 1'b0, sense_above_secondary_overvoltage = 1'b0;
  logic static_overvoltage = 1'b0, overstress_detect = 1'b0;
  logic [4:0] flt = 5'h00;
  logic undervoltage_lockout, undervoltage_protection, fb_floating;
  logic sense_pin_fault, gnd_open, thermal_hot, thermal_cool;
  logic sns_above_boh, sns_below_bol, sns_above_hl, sns_below_ll;
  logic drive_enable, pwm_latch_reset, ctrl_sink_enable, ctrl_ground;
  logic power_good_signal, on_time_ground, ramp_steep, vref_low_select;
  logic blocks_powered, brownout_not_ok_flag, low_line_flag;
  logic secondary_overvoltage;
  int line_mv = 500, temp_c = 25, bad_count = 0, check_count = 0;
  assign {gnd_open, sense_pin_fault, fb_floating, undervoltage_protection,
          undervoltage_lockout} = flt;
  pfs_stage_model stage (.line_mv, .temp_c, .sns_above_boh, .sns_below_bol,
    .sns_above_hl, .sns_below_ll, .thermal_hot, .thermal_cool);
  pfs_supervisor #(.BO_FILT_CYC(64), .LL_FILT_CYC(32), .SECONDARY_OVERVOLTAGE_CLR_CYC(50),
    .OVS_OFF_CYC(40)) dut (.core_clk, .rst, .clk_en, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sns_above_boh, .sns_below_bol, .sns_above_hl, .sns_below_ll,
    .undervoltage_lockout, .thermal_hot, .thermal_cool,
    .undervoltage_protection, .static_overvoltage, .demag_phase,
    .sense_above_secondary_overvoltage, .gnd_open, .fb_floating, .sense_pin_fault,
    .overstress_detect, .drive_enable, .pwm_latch_reset, .ctrl_sink_enable,
    .ctrl_ground, .power_good_signal, .on_time_ground, .ramp_steep,
    .vref_low_select, .blocks_powered, .brownout_not_ok_flag,
    .low_line_flag, .secondary_overvoltage);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ==========
  // Shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cy
  function automatic logic sig(input int s);
    case (s)
      0: return drive_enable;
      1: return brownout_not_ok_flag;
      2: return low_line_flag;
      default: return secondary_overvoltage;
    endcase
  endfunction : sig
  task automatic wt(input int s, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (sig(s) === v) return;
    end
    chk($sformatf("wait %0d", s), v, sig(s));
    close_out();
  endtask : wt
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (i == 20) begin
      chk("ack", 1, wb_ack_o);
      close_out();
    end
  endtask : wb
  // ==========
  // Scenarios
  task automatic t_reset();
    chk("brownout_not_ok_flag", 1, brownout_not_ok_flag);
    chk("low_line_flag", 0, low_line_flag);
    chk("drive", 0, drive_enable);
    chk("ramp", 1, ramp_steep);
  endtask : t_reset
  task automatic t_regs();
    wb(0, pfs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 0, rd);
    wb(1, pfs_pkg::CTRL_OFS, 32'h3);
    wb(0, pfs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 3, rd);
    wb(1, 8'h0C, 32'hFF);
    wb(0, 8'h0C, 32'h0);
    chk("unmapped", 0, rd);
    wb(1, pfs_pkg::CTRL_OFS, 32'h0);
  endtask : t_regs
  task automatic t_brownin();
    chk("brownout_not_ok_flag", 1, brownout_not_ok_flag);
    line_mv <= 2000;
    wt(1, 0, 40);
    wt(0, 1, 40);
    wb(0, pfs_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'hE0, rd);
  endtask : t_brownin
  task automatic t_line();
    line_mv <= 1500;
    cy(50);
    chk("low_line_flag", 0, low_line_flag);
    chk("ramp", 1, ramp_steep);
    line_mv <= 1300;
    cy(32);
    chk("low_line_flag", 0, low_line_flag);
    wt(2, 1, 30);
    cy(2);
    chk("ramp", 0, ramp_steep);
    line_mv <= 2000;
    wt(2, 0, 20);
    cy(2);
    chk("ramp", 1, ramp_steep);
  endtask : t_line
  task automatic t_follow();
    wb(1, pfs_pkg::CTRL_OFS, 32'h3);
    line_mv <= 1300;
    wt(2, 1, 60);
    cy(3);
    chk("vref", 1, vref_low_select);
    wb(1, pfs_pkg::CTRL_OFS, 32'h1);
    cy(3);
    chk("vref", 0, vref_low_select);
    wb(1, pfs_pkg::CTRL_OFS, 32'h3);
    cy(3);
    chk("vref", 1, vref_low_select);
    line_mv <= 2000;
    wt(2, 0, 20);
    cy(3);
    chk("vref", 0, vref_low_select);
  endtask : t_follow
  task automatic t_secondary_overvoltage();
    {demag_phase, sense_above_secondary_overvoltage} <= 2'h3;
    cy(20);
    {demag_phase, sense_above_secondary_overvoltage} <= 2'h0;
    cy(8);
    chk("secondary_overvoltage", 0, secondary_overvoltage);
    {demag_phase, sense_above_secondary_overvoltage} <= 2'h3;
    wt(3, 1, 60);
    cy(1);
    chk("pwm", 1, pwm_latch_reset);
    {demag_phase, sense_above_secondary_overvoltage} <= 2'h0;
    wt(3, 0, 70);
  endtask : t_secondary_overvoltage
  task automatic t_ovs();
    clk_en <= 1'b0;
    overstress_detect <= 1'b1;
    cy(12);
    chk("frozen", 1, drive_enable);
    clk_en <= 1'b1;
    cy(8);
    overstress_detect <= 1'b0;
    wt(0, 0, 12);
    cy(36);
    chk("drive", 0, drive_enable);
    wt(0, 1, 40);
  endtask : t_ovs
  task automatic t_thermal();
    temp_c <= 160;
    wt(0, 0, 12);
    temp_c <= 120;
    cy(30);
    chk("drive", 0, drive_enable);
    temp_c <= 25;
    wt(0, 1, 30);
  endtask : t_thermal
  task automatic t_faults();
    int i;
    logic [31:0] fexp;
    for (i = 0; i < 5; i++) begin
      flt <= 5'h01 << i;
      if (i == 4) begin
        cy(7999);
        chk("drive", 1, drive_enable);
      end
      wt(0, 0, 200);
      cy(2);
      chk("ground", 1, ctrl_ground);
      chk("ontime", 1, on_time_ground);
      chk("good", 0, power_good_signal);
      chk("powered", 0, blocks_powered);
      case (i)
        0: fexp = 32'h01;
        1: fexp = 32'h02;
        2: fexp = 32'h10;
        3: fexp = 32'h20;
        default: fexp = 32'h08;
      endcase
      wb(0, pfs_pkg::FAULT_OFS, 32'h0);
      chk("fault", fexp, rd & 32'h7F);
      flt <= 5'h00;
      wt(0, 1, 60);
    end
  endtask : t_faults
  task automatic t_brownout();
    line_mv <= 800;
    cy(64);
    chk("brownout_not_ok_flag", 0, brownout_not_ok_flag);
    wt(1, 1, 40);
    cy(2);
    chk("sink", 1, ctrl_sink_enable);
    chk("drive", 1, drive_enable);
    static_overvoltage <= 1'b1;
    wt(0, 0, 12);
    cy(2);
    chk("ground", 1, ctrl_ground);
    chk("vref", 0, vref_low_select);
    static_overvoltage <= 1'b0;
    line_mv <= 2000;
    wt(0, 1, 60);
  endtask : t_brownout
  // ==========
  // Main sequence
  initial begin
    cy(10);
    t_reset();
    cy(2);
    rst <= 1'b0;
    cy(20);
    t_regs();
    t_brownin();
    cy(4);
    t_line();
    t_follow();
    t_secondary_overvoltage();
    t_ovs();
    t_thermal();
    t_faults();
    t_brownout();
    close_out();
  end
endmodule : pfs_supervisor_test
